// >>> include/fsrwl_consts.svh
// Opcodes, reset values and timing figures of the flash command admission block
`ifndef FSRWL_CONSTS_SVH
`define FSRWL_CONSTS_SVH

// Opcodes fixed by the command set
`define FSRWL_OP_WREN     8'h06
`define FSRWL_OP_WRDI     8'h04
`define FSRWL_OP_SUSPEND  8'hB0
`define FSRWL_OP_RESUME   8'hD0
`define FSRWL_OP_CERASE_A 8'h60
`define FSRWL_OP_CERASE_B 8'hC7
`define FSRWL_OP_PROTECT  8'h36
`define FSRWL_OP_UNPROT   8'h39

// Serial framing: last bit index within a byte
`define FSRWL_BIT_LAST    3'h7

// Reset values of the flags
`define FSRWL_WLATCH_RST  1'b0
`define FSRWL_PSUSP_RST   1'b0
`define FSRWL_ESUSP_RST   1'b0

// Timing: system clock period and default resume latency, both in ns
`define FSRWL_SYS_CLK_NS  40
`define FSRWL_RES_LAT_NS  60000

`endif

// >>> include/fsrwl_pkg.sv
// Types shared by the flash command admission block
package fsrwl_pkg;

    typedef logic [7:0] fsrwl_byte_t;

    // Array operation tracker, one-hot
    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_PROG   = 4'b0010,
        ST_ERASE  = 4'b0100,
        ST_RESUME = 4'b1000
    } fsrwl_state_t;

    // Admission class of a received opcode
    typedef enum logic [3:0] {
        CL_OTHER, CL_WREN, CL_WRDI, CL_SUSP, CL_RES, CL_PROG, CL_ERASE,
        CL_PROT, CL_SEC, CL_WRSR, CL_PWR
    } fsrwl_class_t;

endpackage

// >>> include/fsrwl_link_if.sv
// Link-domain capture results handed to the system-clock core
`timescale 1ns/1ns
interface fsrwl_link_if;
    logic [7:0] opcode;   // First byte of the latest frame that delivered a full opcode
    logic       op_tog;   // Toggles once per frame that delivered a full opcode
    logic       mid_byte; // High while the frame stands off a byte boundary

    modport link (output opcode, output op_tog, output mid_byte);
    modport core (input opcode, input op_tog, input mid_byte);
endinterface

// >>> core/fsrwl_sync2.sv
// Two-flop level synchroniser into the system clock domain
`timescale 1ns/1ns
module fsrwl_sync2 (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst_n,
    input  wire logic [2:0] i_async,
    output logic      [2:0] o_sync
);
    logic [2:0] meta_q;

    // First stage feeds only the second stage; bit 0 is chip select, idle high
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= 3'h1;
            o_sync <= 3'h1;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule

// >>> core/fsrwl_spi_rx.sv
// Serial-clock side: byte framing and opcode capture of each frame
`timescale 1ns/1ns
`include "fsrwl_consts.svh"
module fsrwl_spi_rx (
    input  wire logic     i_spi_sck,
    input  wire logic     i_spi_cs_n,
    input  wire logic     i_spi_mosi,
    input  wire logic     i_rst_n,
    fsrwl_link_if.link    link
);
    logic [2:0] bit_cnt_q;
    logic [6:0] shift_q;
    logic       got_op_q;
    logic       frame_clr;

    // Reset joins in so the first frame needs no chip select edge beforehand
    assign frame_clr = i_spi_cs_n | ~i_rst_n;

    // Frame state, cleared while chip select is high since the clock stops then
    always_ff @(posedge i_spi_sck or posedge frame_clr) begin
        if (frame_clr) begin
            bit_cnt_q <= 3'h0;
            shift_q   <= 7'h00;
            got_op_q  <= 1'b0;
        end else begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            shift_q   <= {shift_q[5:0], i_spi_mosi};
            if (bit_cnt_q == `FSRWL_BIT_LAST) begin
                got_op_q <= 1'b1;
            end
        end
    end

    // Results outlive the frame so the core can read them after release
    always_ff @(posedge i_spi_sck or negedge i_rst_n) begin
        if (!i_rst_n) begin
            link.opcode   <= 8'h00;
            link.op_tog   <= 1'b0;
            link.mid_byte <= 1'b0;
        end else if (!i_spi_cs_n) begin
            link.mid_byte <= (bit_cnt_q != `FSRWL_BIT_LAST);
            if (bit_cnt_q == `FSRWL_BIT_LAST && !got_op_q) begin
                link.opcode <= {shift_q, i_spi_mosi};
                link.op_tog <= ~link.op_tog;
            end
        end
    end
endmodule

// >>> core/fsrwl_top.sv
// Flash command admission: write latch, suspend table and resume sequencing
`timescale 1ns/1ns
`include "fsrwl_consts.svh"
module fsrwl_top #(
    parameter logic [7:0] P_OP_PROG      = 8'h02,
    parameter logic [7:0] P_OP_PROG_DUAL = 8'hA2,
    parameter logic [7:0] P_OP_BERASE_4K = 8'h20,
    parameter logic [7:0] P_OP_BERASE_32 = 8'h52,
    parameter logic [7:0] P_OP_BERASE_64 = 8'hD8,
    parameter logic [7:0] P_OP_LOCKDOWN  = 8'h33,
    parameter logic [7:0] P_OP_FREEZE    = 8'h34,
    parameter logic [7:0] P_OP_OTP_PROG  = 8'h9B,
    parameter logic [7:0] P_OP_WRSR_1    = 8'h01,
    parameter logic [7:0] P_OP_WRSR_2    = 8'h31,
    parameter logic [7:0] P_OP_DEEP_PD   = 8'hB9,
    parameter logic [7:0] P_OP_WAKE      = 8'hAB,
    parameter int unsigned P_RES_LAT_NS  = `FSRWL_RES_LAT_NS
) (
    input  wire logic          i_sys_clk,
    input  wire logic          i_rst_n,
    input  wire logic          i_spi_sck,
    input  wire logic          i_spi_cs_n,
    input  wire logic          i_spi_mosi,
    input  wire logic          i_op_done,
    output logic               o_write_latch_flag,
    output logic               o_prog_suspended_flag,
    output logic               o_erase_suspended_flag,
    output logic               o_ready_busy_flag,
    output logic               o_prog_start,
    output logic               o_erase_start,
    output logic               o_suspend_req,
    output logic               o_resume_prog,
    output logic               o_resume_erase,
    output logic               o_exec_pulse,
    output fsrwl_pkg::fsrwl_byte_t o_exec_opcode,
    output logic               o_refused
);
    import fsrwl_pkg::*;

    // Resume latency is a longest time, so it rounds down, never below one cycle
    localparam int unsigned RES_CYC_RAW = P_RES_LAT_NS / `FSRWL_SYS_CLK_NS;
    localparam int unsigned RES_CYC     = (RES_CYC_RAW < 1) ? 1 : RES_CYC_RAW;
    localparam logic [15:0] RES_LOAD    = 16'(RES_CYC - 1);

    ////////////////////////////////////////////////////////////////////////////
    // Opcode classification

    function automatic fsrwl_class_t classify(input fsrwl_byte_t op);
        fsrwl_class_t cl;
        cl = CL_OTHER;
        if (op == `FSRWL_OP_WREN) begin
            cl = CL_WREN;
        end else if (op == `FSRWL_OP_WRDI) begin
            cl = CL_WRDI;
        end else if (op == `FSRWL_OP_SUSPEND) begin
            cl = CL_SUSP;
        end else if (op == `FSRWL_OP_RESUME) begin
            cl = CL_RES;
        end else if (op == P_OP_PROG || op == P_OP_PROG_DUAL) begin
            cl = CL_PROG;
        end else if (op == P_OP_BERASE_4K || op == P_OP_BERASE_32
                     || op == P_OP_BERASE_64 || op == `FSRWL_OP_CERASE_A
                     || op == `FSRWL_OP_CERASE_B) begin
            cl = CL_ERASE;
        end else if (op == `FSRWL_OP_PROTECT || op == `FSRWL_OP_UNPROT) begin
            cl = CL_PROT;
        end else if (op == P_OP_LOCKDOWN || op == P_OP_FREEZE
                     || op == P_OP_OTP_PROG) begin
            cl = CL_SEC;
        end else if (op == P_OP_WRSR_1 || op == P_OP_WRSR_2) begin
            cl = CL_WRSR;
        end else if (op == P_OP_DEEP_PD || op == P_OP_WAKE) begin
            cl = CL_PWR;
        end
        return cl;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Link capture and crossing

    fsrwl_link_if link_if ();

    fsrwl_spi_rx u_spi_rx (
        .i_spi_sck  (i_spi_sck),
        .i_spi_cs_n (i_spi_cs_n),
        .i_spi_mosi (i_spi_mosi),
        .i_rst_n    (i_rst_n),
        .link       (link_if.link)
    );

    logic [2:0] sync_w;

    fsrwl_sync2 u_sync2 (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_async   ({link_if.mid_byte, link_if.op_tog, i_spi_cs_n}),
        .o_sync    (sync_w)
    );

    logic cs_hi_q;
    logic end_q;
    logic last_tog_q;
    logic frame_ok;

    // Release edge, judged one cycle later so the toggle has surely arrived
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cs_hi_q    <= 1'b1;
            end_q      <= 1'b0;
            last_tog_q <= 1'b0;
        end else begin
            cs_hi_q <= sync_w[0];
            end_q   <= sync_w[0] & ~cs_hi_q;
            if (end_q) begin
                last_tog_q <= sync_w[1];
            end
        end
    end

    // A full opcode and a byte-aligned release, else nothing happens
    assign frame_ok = end_q & (sync_w[1] ^ last_tog_q) & ~sync_w[2];

    ////////////////////////////////////////////////////////////////////////////
    // Admission decision

    fsrwl_state_t state_q;
    fsrwl_state_t state_d;
    fsrwl_class_t cls;
    fsrwl_byte_t  opc;
    logic         wlatch_q;
    logic         psusp_q;
    logic         esusp_q;
    logic         res_prog_q;
    logic [15:0]  res_cnt_q;
    logic         susp;
    logic         idle;
    logic         do_wren;
    logic         do_wrdi;
    logic         do_susp;
    logic         do_res;
    logic         do_prog;
    logic         do_erase;
    logic         do_gated;
    logic         do_exec;
    logic         do_refuse;

    // Opcode only read once its toggle has crossed; it is stable by then
    assign opc  = link_if.opcode;
    assign cls  = classify(opc);
    assign susp = psusp_q | esusp_q;
    assign idle = (state_q == ST_IDLE);

    // One verdict per frame; refused frames touch no flag at all
    always_comb begin
        do_wren   = 1'b0;
        do_wrdi   = 1'b0;
        do_susp   = 1'b0;
        do_res    = 1'b0;
        do_prog   = 1'b0;
        do_erase  = 1'b0;
        do_gated  = 1'b0;
        do_exec   = 1'b0;
        do_refuse = 1'b0;
        if (frame_ok) begin
            case (cls)
                CL_WREN: begin
                    do_refuse = psusp_q;
                    do_wren   = ~psusp_q;
                end
                CL_WRDI: begin
                    do_refuse = psusp_q;
                    do_wrdi   = ~psusp_q;
                end
                CL_SUSP: begin
                    // Resume still settling, or nothing running
                    if (psusp_q || state_q == ST_RESUME || idle || i_op_done) begin
                        do_refuse = 1'b1;
                    end else begin
                        do_susp = 1'b1;
                    end
                end
                CL_RES: begin
                    // Latch state plays no part here
                    do_res    = idle & susp;
                    do_refuse = ~(idle & susp);
                end
                CL_PROG: begin
                    if (psusp_q || !wlatch_q || !idle) begin
                        do_refuse = 1'b1;
                    end else begin
                        do_prog = 1'b1;
                    end
                end
                CL_ERASE: begin
                    if (susp || !wlatch_q || !idle) begin
                        do_refuse = 1'b1;
                    end else begin
                        do_erase = 1'b1;
                    end
                end
                CL_PROT, CL_SEC, CL_WRSR: begin
                    if (susp || !wlatch_q || !idle) begin
                        do_refuse = 1'b1;
                    end else begin
                        do_gated = 1'b1;
                    end
                end
                CL_PWR: begin
                    do_refuse = susp;
                    do_exec   = ~susp;
                end
                default: begin
                    // Reads, reset and ID reads pass in any state
                    do_exec = 1'b1;
                end
            endcase
            do_exec = do_exec | do_prog | do_erase | do_gated;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write enable latch

    // Write-type commands consume the latch when they start
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wlatch_q <= `FSRWL_WLATCH_RST;
        end else if (do_wren) begin
            wlatch_q <= 1'b1;
        end else if (do_wrdi || do_prog || do_erase || do_gated) begin
            wlatch_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Suspended flags

    // Program suspend may stack on an erase suspend; both flags then stand
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            psusp_q <= `FSRWL_PSUSP_RST;
            esusp_q <= `FSRWL_ESUSP_RST;
        end else begin
            if (do_susp && state_q == ST_PROG) begin
                psusp_q <= 1'b1;
            end else if (do_res && psusp_q) begin
                psusp_q <= 1'b0;
            end
            if (do_susp && state_q == ST_ERASE) begin
                esusp_q <= 1'b1;
            end else if (do_res && !psusp_q) begin
                esusp_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Operation tracker

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (do_prog) begin
                    state_d = ST_PROG;
                end else if (do_erase) begin
                    state_d = ST_ERASE;
                end else if (do_res) begin
                    state_d = ST_RESUME;
                end
            end
            ST_PROG, ST_ERASE: begin
                if (do_susp || i_op_done) begin
                    state_d = ST_IDLE;
                end
            end
            ST_RESUME: begin
                if (res_cnt_q == 16'h0000) begin
                    state_d = res_prog_q ? ST_PROG : ST_ERASE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Resume latency window and which operation it brings back
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            res_cnt_q  <= 16'h0000;
            res_prog_q <= 1'b0;
        end else if (do_res) begin
            res_cnt_q  <= RES_LOAD;
            res_prog_q <= psusp_q;
        end else if (state_q == ST_RESUME && res_cnt_q != 16'h0000) begin
            res_cnt_q <= res_cnt_q - 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs to the array engine and status

    // Resume pulses tell the engine to continue, not to restart
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_prog_start   <= 1'b0;
            o_erase_start  <= 1'b0;
            o_suspend_req  <= 1'b0;
            o_resume_prog  <= 1'b0;
            o_resume_erase <= 1'b0;
            o_exec_pulse   <= 1'b0;
            o_refused      <= 1'b0;
        end else begin
            o_prog_start   <= do_prog;
            o_erase_start  <= do_erase;
            o_suspend_req  <= do_susp;
            o_resume_prog  <= do_res & psusp_q;
            o_resume_erase <= do_res & ~psusp_q;
            o_exec_pulse   <= do_exec;
            o_refused      <= do_refuse;
        end
    end

    // Opcode of the last command passed on for execution
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_exec_opcode <= 8'h00;
        end else if (do_exec) begin
            o_exec_opcode <= opc;
        end
    end

    // Busy follows the tracker; a resume reports busy at once
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_ready_busy_flag <= 1'b0;
        end else begin
            o_ready_busy_flag <= (state_d != ST_IDLE);
        end
    end

    assign o_write_latch_flag     = wlatch_q;
    assign o_prog_suspended_flag  = psusp_q;
    assign o_erase_suspended_flag = esusp_q;
endmodule

// >>> sim/fsrwl_host_model.sv
// Host serial controller model that frames flash commands
`timescale 1ns/1ns
module fsrwl_host_model (
    output logic o_spi_sck,
    output logic o_spi_cs_n,
    output logic o_spi_mosi
);
    // Link idles with chip select high and clock low
    initial begin
        o_spi_sck = 1'b0;
        o_spi_cs_n = 1'b1;
        o_spi_mosi = 1'b0;
    end

    // Mode 0 frame of n bits; clock stands still outside frames
    task automatic send(input logic [7:0] op, input int n);
        logic [15:0] bits;
        bits = {op, 8'hA5}; // Trailing byte is junk
        #13;
        o_spi_cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            o_spi_mosi = bits[15 - i]; // MSB first
            #80 o_spi_sck = 1'b1;
            #80 o_spi_sck = 1'b0;
        end
        #80 o_spi_cs_n = 1'b1;
        o_spi_mosi = ~o_spi_mosi; // Released line must not hold the last bit
    endtask
endmodule

// >>> sim/fsrwl_top_chk.sv
// Concurrent checks on the flash command admission ports
`timescale 1ns/1ns
`include "fsrwl_consts.svh"
module fsrwl_top_chk #(
    parameter int unsigned P_RES_CYC = `FSRWL_RES_LAT_NS / `FSRWL_SYS_CLK_NS
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_spi_cs_n,
    input wire logic o_write_latch_flag,
    input wire logic o_prog_suspended_flag,
    input wire logic o_erase_suspended_flag,
    input wire logic o_ready_busy_flag,
    input wire logic o_prog_start,
    input wire logic o_erase_start,
    input wire logic o_suspend_req,
    input wire logic o_resume_prog,
    input wire logic o_resume_erase,
    input wire logic o_refused
);
    logic        cs_q;
    logic [3:0]  gap_q;
    logic        win;
    logic [15:0] res_age_q;

    // Cycles since frame end; async pin, so allow a cycle of slack
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cs_q <= 1'b1;
            gap_q <= 4'hF;
        end else begin
            cs_q <= i_spi_cs_n;
            if (i_spi_cs_n && !cs_q) gap_q <= 4'h0;
            else if (gap_q != 4'hF) gap_q <= gap_q + 4'h1;
        end
    end
    assign win = (gap_q >= 4'h2) && (gap_q <= 4'h6);

    // Cycles since the last resume pulse; a suspend must wait out the latency
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            res_age_q <= 16'hFFFF;
        end else if (o_resume_prog || o_resume_erase) begin
            res_age_q <= 16'h0000;
        end else if (res_age_q != 16'hFFFF) begin
            res_age_q <= res_age_q + 16'h0001;
        end
    end

    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    ////////////////////////////////////////////////////////////////////////////
    property p_wel_frame;
        $changed(o_write_latch_flag) |-> win;
    endproperty
    a_wel_frame: assert property (p_wel_frame) else $error("latch moved off frame end");
    property p_prog;
        o_prog_start |-> $past(o_write_latch_flag) && !$past(o_prog_suspended_flag);
    endproperty
    a_prog: assert property (p_prog) else $error("program start not allowed");
    property p_erase;
        o_erase_start |-> $past(o_write_latch_flag) && !$past(o_prog_suspended_flag)
            && !$past(o_erase_suspended_flag);
    endproperty
    a_erase: assert property (p_erase) else $error("erase start not allowed");
    property p_res_prog;
        o_resume_prog |-> win && $past(o_prog_suspended_flag)
            ##[0:1] (!o_prog_suspended_flag && o_ready_busy_flag);
    endproperty
    a_res_prog: assert property (p_res_prog) else $error("program resume wrong");
    property p_res_erase;
        o_resume_erase |-> !$past(o_prog_suspended_flag) && $past(o_erase_suspended_flag)
            ##[0:1] (!o_erase_suspended_flag && o_ready_busy_flag);
    endproperty
    a_res_erase: assert property (p_res_erase) else $error("erase resume wrong");
    property p_susp;
        o_suspend_req |-> win ##[0:2]
            (!o_ready_busy_flag && (o_prog_suspended_flag || o_erase_suspended_flag));
    endproperty
    a_susp: assert property (p_susp) else $error("suspend flags wrong");
    property p_refused;
        o_refused |-> ($stable(o_write_latch_flag) && $stable(o_prog_suspended_flag)
            && $stable(o_erase_suspended_flag)) [*2];
    endproperty
    a_refused: assert property (p_refused) else $error("refused frame changed flags");
    property p_no_susp;
        o_suspend_req |-> (res_age_q >= 16'(P_RES_CYC - 1));
    endproperty
    a_no_susp: assert property (p_no_susp) else $error("suspend during resume");

    c_both: cover property (o_prog_suspended_flag && o_erase_suspended_flag);
    c_res_erase: cover property (o_resume_erase);
    c_refused: cover property (o_refused);
endmodule

bind fsrwl_top fsrwl_top_chk #(.P_RES_CYC(P_RES_LAT_NS / `FSRWL_SYS_CLK_NS))
    fsrwl_top_chk_inst (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_spi_cs_n(i_spi_cs_n),
    .o_write_latch_flag(o_write_latch_flag), .o_prog_suspended_flag(o_prog_suspended_flag),
    .o_erase_suspended_flag(o_erase_suspended_flag), .o_ready_busy_flag(o_ready_busy_flag),
    .o_prog_start(o_prog_start), .o_erase_start(o_erase_start),
    .o_suspend_req(o_suspend_req), .o_resume_prog(o_resume_prog),
    .o_resume_erase(o_resume_erase), .o_refused(o_refused)
);

// >>> sim/test_flash_suspend_resume_write_latch.sv
// Self-checking bench for the flash command admission block
`timescale 1ns/1ns
module test_flash_suspend_resume_write_latch;
    import fsrwl_pkg::*;
    logic        i_sys_clk, i_rst_n, i_op_done, clr;
    wire         sck, cs_n, mosi;
    logic        wlatch, psusp, esusp, busy, p_st, e_st, sus, rp, re, ex, rf;
    fsrwl_byte_t xop;
    logic [6:0]  seen;
    int          err_count, checked, i;
    wire  [3:0]  flags = {wlatch, psusp, esusp, busy};
    // First 15 must be refused in program suspend, the rest pass
    logic [7:0]  ops [21] = '{8'h06, 8'h04, 8'hB0, 8'h20, 8'h60, 8'h02, 8'h36, 8'h39,
        8'h33, 8'h34, 8'h9B, 8'h01, 8'h31, 8'hB9, 8'hAB,
        8'h03, 8'h0B, 8'h05, 8'h9F, 8'hF0, 8'h3C};

    fsrwl_host_model fsrwl_host_model_inst (.o_spi_sck(sck), .o_spi_cs_n(cs_n),
        .o_spi_mosi(mosi));
    fsrwl_top #(.P_RES_LAT_NS(4000)) fsrwl_top_inst (
        .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_spi_sck(sck), .i_spi_cs_n(cs_n),
        .i_spi_mosi(mosi), .i_op_done(i_op_done), .o_write_latch_flag(wlatch),
        .o_prog_suspended_flag(psusp), .o_erase_suspended_flag(esusp),
        .o_ready_busy_flag(busy),
        .o_prog_start(p_st), .o_erase_start(e_st), .o_suspend_req(sus),
        .o_resume_prog(rp), .o_resume_erase(re), .o_exec_pulse(ex),
        .o_exec_opcode(xop), .o_refused(rf));

    initial begin
        i_sys_clk = 1'b0;
        forever #20 i_sys_clk = ~i_sys_clk;
    end

    // Pulses are one cycle wide, so latch them per frame
    always @(posedge i_sys_clk) begin
        if (clr) seen <= 7'h00;
        else seen <= seen | {p_st, e_st, sus, rp, re, ex, rf};
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One frame, then flags and pulses compared well past the answer
    task automatic step(input logic [7:0] op, input int n, input logic [3:0] ef,
                        input logic [6:0] ep);
        @(posedge i_sys_clk) clr <= 1'b1;
        @(posedge i_sys_clk) clr <= 1'b0;
        fsrwl_host_model_inst.send(op, n);
        repeat (12) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        chk({4'h0, flags}, {4'h0, ef});
        chk({1'b0, seen}, {1'b0, ep});
    endtask

    // Engine reports the running operation finished after the latency
    task automatic finish_op;
        repeat (110) @(posedge i_sys_clk);
        i_op_done <= 1'b1;
        @(posedge i_sys_clk) i_op_done <= 1'b0;
        repeat (3) @(negedge i_sys_clk);
    endtask

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        i_rst_n = 1'b0;
        i_op_done = 1'b0;
        clr = 1'b1;
        err_count = 0;
        checked = 0;
        repeat (3) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        repeat (4) @(negedge i_sys_clk);
        chk({4'h0, flags}, 8'h00);
        step(8'h06, 16, 4'h8, 7'h00);
        step(8'h04, 8, 4'h0, 7'h00);
        step(8'h06, 5, 4'h0, 7'h00);
        step(8'h06, 12, 4'h0, 7'h00);
        step(8'h02, 16, 4'h0, 7'h01);
        step(8'h06, 8, 4'h8, 7'h00);
        step(8'h02, 16, 4'h1, 7'h42);
        step(8'hB0, 8, 4'h4, 7'h10);
        for (i = 0; i < 21; i++) begin
            step(ops[i], 8, 4'h4, (i < 15) ? 7'h01 : 7'h02);
            if (i >= 15) chk(xop, ops[i]);
        end
        step(8'hD0, 4, 4'h4, 7'h00);
        step(8'hD0, 16, 4'h1, 7'h08);
        step(8'hB0, 8, 4'h1, 7'h01);
        finish_op;
        chk({4'h0, flags}, 8'h00);
        step(8'h06, 8, 4'h8, 7'h00);
        step(8'h20, 16, 4'h1, 7'h22);
        step(8'hB0, 8, 4'h2, 7'h10);
        step(8'h04, 8, 4'h2, 7'h00);
        step(8'h06, 8, 4'hA, 7'h00);
        step(8'h60, 8, 4'hA, 7'h01);
        step(8'h02, 16, 4'h3, 7'h42);
        step(8'hB0, 8, 4'h6, 7'h10);
        step(8'hD0, 8, 4'h3, 7'h08);
        finish_op;
        chk({4'h0, flags}, 8'h02);
        step(8'hD0, 8, 4'h1, 7'h04);
        finish_op;
        chk({4'h0, flags}, 8'h00);
        step(8'h36, 16, 4'h0, 7'h01);
        step(8'h06, 8, 4'h8, 7'h00);
        step(8'h01, 16, 4'h0, 7'h02);
        chk(xop, 8'h01);
        step(8'hB9, 8, 4'h0, 7'h02);
        give_verdict;
    end

    // Cut a hang well past the expected run length
    initial begin
        #600000;
        err_count++;
        give_verdict;
    end
endmodule
